// >>> rtl/deser_link_config_pkg.sv
package deser_link_config_pkg;

    // register offsets on the control interface
    localparam logic [7:0] GENERAL_CONFIG_1_OFFSET = 8'h03;
    localparam logic [7:0] EQ_GAIN_OFFSET = 8'h04;

    // reset values
    localparam logic [7:0] GENERAL_CONFIG_1_RESET = 8'hE9;
    localparam logic [7:0] EQ_GAIN_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // general configuration bit positions
    localparam int PARITY_CHECK_BIT = 7;
    localparam int CRC_GEN_BIT = 6;
    localparam int IO_AUTO_BIT = 5;
    localparam int IO_MODE_BIT = 4;
    localparam int PASSTHROUGH_BIT = 3;
    localparam int AUTOACK_BIT = 2;
    localparam int PARITY_CLEAR_BIT = 1;
    localparam int SAMPLE_EDGE_BIT = 0;

    // one register access request
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_type;

    // decoded configuration levels
    typedef struct packed {
        logic parity_check_en;
        logic crc_gen_en;
        logic io_supply_auto;
        logic io_supply_3v3_select;
        logic passthrough_en;
        logic remote_write_autoack;
        logic output_sample_edge_select;
    } link_config_type;

    // transaction offered for forwarding to the remote side
    typedef struct packed {
        logic write;
        logic to_serializer;
        logic pass_all;
        logic [6:0] addr;
    } fwd_request_type;

    // control channel request handshake
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_BUSY = 2'b10
    } link_state_type;

endpackage

// >>> rtl/deser_link_config_regs.sv
`timescale 1ns/1ps

// How it works
// - bit 7 of general config enables the forward parity checker.
// - bit 6 of general config enables the back-channel CRC generator.
// - bit 5 set selects auto detection of the io supply level.
// - bit 4 picks the manual io level, one for 3.3V, zero for 1.8V.
// - bit 3 enables i2c pass-through to the remote side.
// - bit 2 makes remote writes to the serializer alias or marked pass-all acknowledged at once, locally.
// - auto-acknowledged writes are still forwarded, alias hits remapped.
// - writing one to bit 1 clears the parity counters, then self-clears.
// - bit 0 picks the audio output launch edge, one rising.
// - in equalizer bypass the gain register sets the equalizer gain.
// - registers answer both the local and the remote channel.
// - serializer alias traffic goes to the remote serializer address.
module deser_link_config_regs
    import deser_link_config_pkg::*;
(
    // device clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // local register access
    input wire logic i_loc_req,
    input wire reg_access_type i_loc_acc,
    output logic o_loc_ack,
    output logic [7:0] o_loc_rdata,
    // remote register access, control channel clock
    input wire logic i_link_clk,
    input wire logic i_rem_req,
    input wire reg_access_type i_rem_acc,
    output logic o_rem_ack,
    output logic o_rem_busy,
    output logic [7:0] o_rem_rdata,
    // transactions offered for forwarding
    input wire logic i_fwd_req,
    input wire fwd_request_type i_fwd,
    input wire logic [6:0] i_remote_serializer_address,
    output logic o_fwd_valid,
    output logic o_fwd_write,
    output logic [6:0] o_fwd_addr,
    output logic o_fwd_early_ack,
    // pin and equalizer inputs
    input wire logic i_io_supply_detect_3v3,
    input wire logic i_adaptive_equalizer_bypass,
    input wire logic [7:0] i_adaptive_equalizer_gain,
    // configuration outputs
    output link_config_type o_config,
    output logic o_io_supply_level_3v3,
    output logic o_parity_count_clear,
    output logic [7:0] o_equalizer_gain_code
);

////////////////////////////////////////////////////////////////////////////////

logic [1:0] rst_pipe;
logic rst_n;
logic [1:0] link_rst_pipe;
logic link_rst_n;

// reset release synchronised per domain, assertion stays asynchronous
always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        rst_pipe <= 2'b00;
    else
        rst_pipe <= {rst_pipe[0], 1'b1};
end

assign rst_n = rst_pipe[1];
always_ff @(posedge i_link_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        link_rst_pipe <= 2'b00;
    else
        link_rst_pipe <= {link_rst_pipe[0], 1'b1};
end

assign link_rst_n = link_rst_pipe[1];
////////////////////////////////////////////////////////////////////////////////

link_state_type link_state;
reg_access_type rem_hold;
logic req_tgl;
logic ack_tgl;
logic [1:0] ack_sync;
logic ack_seen;
logic ack_event;
logic [7:0] rem_rdata_hold;
// link side: hold one request until the device side answers
always_ff @(posedge i_link_clk or negedge link_rst_n)
begin
    if (!link_rst_n)
    begin
        link_state <= LINK_IDLE;
        rem_hold <= '0;
        req_tgl <= 1'b0;
    end
    else
    begin
        unique case (link_state)
            LINK_IDLE:
            begin
                if (i_rem_req)
                begin
                    rem_hold <= i_rem_acc;
                    req_tgl <= ~req_tgl;
                    link_state <= LINK_BUSY;
                end
            end
            LINK_BUSY:
            begin
                if (ack_event)
                    link_state <= LINK_IDLE;
            end
        endcase
    end
end

assign ack_event = ack_sync[1] != ack_seen;
// answer toggle crosses back; read data is stable while it travels
always_ff @(posedge i_link_clk or negedge link_rst_n)
begin
    if (!link_rst_n)
    begin
        ack_sync <= 2'b00;
        ack_seen <= 1'b0;
        o_rem_ack <= 1'b0;
        o_rem_busy <= 1'b0;
        o_rem_rdata <= 8'h00;
    end
    else
    begin
        ack_sync <= {ack_sync[0], ack_tgl};
        ack_seen <= ack_sync[1];
        o_rem_ack <= ack_event;
        o_rem_busy <= (link_state == LINK_IDLE) ? i_rem_req : !ack_event;
        if (ack_event)
            o_rem_rdata <= rem_rdata_hold;
    end
end

////////////////////////////////////////////////////////////////////////////////

logic [1:0] req_sync;
logic req_seen;
logic rem_pending;
logic rem_go;
logic acc_go;
reg_access_type acc;
logic [7:0] general_config;
logic [7:0] eq_gain;
// read mux, unmapped offsets answer zero
function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                        input logic [7:0] gc,
                                        input logic [7:0] eq);
    if (addr == GENERAL_CONFIG_1_OFFSET)
        return gc;
    else if (addr == EQ_GAIN_OFFSET)
        return eq;
    else
        return UNMAPPED_READ_VALUE;
endfunction
// local wins a tie; the remote request waits until a cycle with no local request
assign rem_pending = req_sync[1] != req_seen;
assign rem_go = rem_pending && !i_loc_req;
assign acc_go = i_loc_req || rem_pending;
assign acc = i_loc_req ? i_loc_acc : rem_hold;
// device side of the request handshake
always_ff @(posedge i_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        req_sync <= 2'b00;
        req_seen <= 1'b0;
        ack_tgl <= 1'b0;
        rem_rdata_hold <= 8'h00;
    end
    else
    begin
        req_sync <= {req_sync[0], req_tgl};
        if (rem_go)
        begin
            req_seen <= req_sync[1];
            ack_tgl <= ~ack_tgl;
            rem_rdata_hold <= read_reg(rem_hold.addr, general_config,
                                       eq_gain);
        end
    end
end

// general configuration, clear bit drops by itself next cycle
always_ff @(posedge i_clk or negedge rst_n)
begin
    if (!rst_n)
        general_config <= GENERAL_CONFIG_1_RESET;
    else if (acc_go && acc.write && acc.addr == GENERAL_CONFIG_1_OFFSET)
        general_config <= acc.wdata;
    else
        general_config[PARITY_CLEAR_BIT] <= 1'b0;
end

// equalizer gain code
always_ff @(posedge i_clk or negedge rst_n)
begin
    if (!rst_n)
        eq_gain <= EQ_GAIN_RESET;
    else if (acc_go && acc.write && acc.addr == EQ_GAIN_OFFSET)
        eq_gain <= acc.wdata;
end

// local answer one cycle after the request, read shows old contents
always_ff @(posedge i_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        o_loc_ack <= 1'b0;
        o_loc_rdata <= 8'h00;
    end
    else
    begin
        o_loc_ack <= i_loc_req;
        if (i_loc_req)
            o_loc_rdata <= read_reg(i_loc_acc.addr, general_config, eq_gain);
    end
end

////////////////////////////////////////////////////////////////////////////////

logic [1:0] io_sync;
// decoded controls toward the link datapath
always_ff @(posedge i_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        o_config <= '0;
        o_parity_count_clear <= 1'b0;
        o_equalizer_gain_code <= 8'h00;
    end
    else
    begin
        o_config.parity_check_en <= general_config[PARITY_CHECK_BIT];
        o_config.crc_gen_en <= general_config[CRC_GEN_BIT];
        o_config.io_supply_auto <= general_config[IO_AUTO_BIT];
        o_config.io_supply_3v3_select <= general_config[IO_MODE_BIT];
        o_config.passthrough_en <= general_config[PASSTHROUGH_BIT];
        o_config.remote_write_autoack <= general_config[AUTOACK_BIT];
        o_config.output_sample_edge_select <=
            general_config[SAMPLE_EDGE_BIT];
        o_parity_count_clear <= general_config[PARITY_CLEAR_BIT];
        // manual code only counts when adaptation is bypassed
        o_equalizer_gain_code <= i_adaptive_equalizer_bypass ?
            eq_gain : i_adaptive_equalizer_gain;
    end
end

// supply detect pin is asynchronous to the device clock
always_ff @(posedge i_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        io_sync <= 2'b00;
        o_io_supply_level_3v3 <= 1'b0;
    end
    else
    begin
        io_sync <= {io_sync[0], i_io_supply_detect_3v3};
        o_io_supply_level_3v3 <= general_config[IO_AUTO_BIT] ?
            io_sync[1] : general_config[IO_MODE_BIT];
    end
end

// forwarding: remap alias hits and acknowledge writes early on request
always_ff @(posedge i_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        o_fwd_valid <= 1'b0;
        o_fwd_write <= 1'b0;
        o_fwd_addr <= 7'h00;
        o_fwd_early_ack <= 1'b0;
    end
    else
    begin
        o_fwd_valid <= i_fwd_req;
        o_fwd_write <= i_fwd.write;
        o_fwd_addr <= i_fwd.to_serializer ?
            i_remote_serializer_address : i_fwd.addr;
        // trusts the host to enable this only with link_a up
        o_fwd_early_ack <= i_fwd_req && i_fwd.write
            && general_config[AUTOACK_BIT]
            && (i_fwd.to_serializer || i_fwd.pass_all);
    end
end

////////////////////////////////////////////////////////////////////////////////

logic gc_loc_wr;
assign gc_loc_wr = i_loc_req && i_loc_acc.write
    && i_loc_acc.addr == GENERAL_CONFIG_1_OFFSET;

reset_value_a: assert property (
    @(posedge i_clk) $rose(rst_n) |-> general_config == GENERAL_CONFIG_1_RESET)
    else $error("general config reset value wrong");
parity_enable_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    gc_loc_wr |-> ##2 o_config.parity_check_en == $past(i_loc_acc.wdata[7], 2))
    else $error("parity checker enable does not follow write");
crc_enable_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    $changed(general_config[CRC_GEN_BIT]) |=>
    o_config.crc_gen_en == $past(general_config[CRC_GEN_BIT]))
    else $error("crc generator enable stale");
io_level_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    !general_config[IO_AUTO_BIT] |=>
    o_io_supply_level_3v3 == $past(general_config[IO_MODE_BIT]))
    else $error("manual io level not applied");
pass_through_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    gc_loc_wr ##1 !gc_loc_wr |=>
    o_config.passthrough_en == $past(i_loc_acc.wdata[3], 2))
    else $error("pass-through enable wrong");
early_ack_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    i_fwd_req && i_fwd.write && i_fwd.to_serializer
    && general_config[AUTOACK_BIT] |=> o_fwd_early_ack && o_fwd_valid)
    else $error("remote write not acknowledged early");
alias_remap_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    i_fwd_req && i_fwd.to_serializer |=>
    o_fwd_addr == $past(i_remote_serializer_address))
    else $error("alias not remapped to serializer address");
clear_pulse_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    gc_loc_wr && i_loc_acc.wdata[1] |-> ##2 o_parity_count_clear)
    else $error("parity counter clear not pulsed");
self_clear_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    general_config[PARITY_CLEAR_BIT] && !acc_go |=>
    !general_config[PARITY_CLEAR_BIT])
    else $error("parity clear bit did not self-clear");
edge_select_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    gc_loc_wr |-> ##2
    o_config.output_sample_edge_select == $past(i_loc_acc.wdata[0], 2))
    else $error("sample edge select wrong");
eq_bypass_a: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    i_adaptive_equalizer_bypass |=> o_equalizer_gain_code == $past(eq_gain))
    else $error("manual gain not applied in bypass");
remote_answer_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_n)
    link_state == LINK_IDLE && i_rem_req |-> ##[3:40] o_rem_ack)
    else $error("remote access not answered in time");

remote_write_c: cover property (@(posedge i_link_clk) disable iff
    (!link_rst_n) o_rem_ack && rem_hold.write);
clear_pulse_c: cover property (@(posedge i_clk) disable iff (!rst_n)
    o_parity_count_clear);
early_ack_c: cover property (@(posedge i_clk) disable iff (!rst_n)
    o_fwd_early_ack);
tie_c: cover property (@(posedge i_clk) disable iff (!rst_n)
    i_loc_req && rem_pending);

endmodule

// >>> tb/deser_link_config_regs_tb_top.sv
`timescale 1ns/1ps
module deser_link_config_regs_tb_top;
    import deser_link_config_pkg::*;
    logic i_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_loc_req = 1'b0;
    reg_access_type i_loc_acc = '0;
    logic i_fwd_req = 1'b0;
    fwd_request_type i_fwd = '0;
    logic [6:0] i_remote_serializer_address = 7'h2B;
    logic i_io_supply_detect_3v3 = 1'b0;
    logic i_adaptive_equalizer_bypass = 1'b0;
    logic [7:0] i_adaptive_equalizer_gain = 8'h00;
    logic i_rem_req;
    reg_access_type i_rem_acc;
    logic o_loc_ack, o_rem_ack, o_rem_busy, o_fwd_valid, o_fwd_write;
    logic o_fwd_early_ack, o_io_supply_level_3v3, o_parity_count_clear;
    logic [7:0] o_loc_rdata, o_rem_rdata, o_equalizer_gain_code;
    logic [6:0] o_fwd_addr;
    link_config_type o_config;
    int n_checks = 0;
    int n_mismatch = 0;

    // two unrelated clocks: 4 ns device, 6 ns control channel
    always #2 i_clk = ~i_clk;
    always #3 i_link_clk = ~i_link_clk;

    deser_link_config_regs uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_loc_req(i_loc_req), .i_loc_acc(i_loc_acc),
        .o_loc_ack(o_loc_ack), .o_loc_rdata(o_loc_rdata),
        .i_link_clk(i_link_clk), .i_rem_req(i_rem_req),
        .i_rem_acc(i_rem_acc), .o_rem_ack(o_rem_ack),
        .o_rem_busy(o_rem_busy), .o_rem_rdata(o_rem_rdata),
        .i_fwd_req(i_fwd_req), .i_fwd(i_fwd),
        .i_remote_serializer_address(i_remote_serializer_address),
        .o_fwd_valid(o_fwd_valid), .o_fwd_write(o_fwd_write),
        .o_fwd_addr(o_fwd_addr), .o_fwd_early_ack(o_fwd_early_ack),
        .i_io_supply_detect_3v3(i_io_supply_detect_3v3),
        .i_adaptive_equalizer_bypass(i_adaptive_equalizer_bypass),
        .i_adaptive_equalizer_gain(i_adaptive_equalizer_gain),
        .o_config(o_config),
        .o_io_supply_level_3v3(o_io_supply_level_3v3),
        .o_parity_count_clear(o_parity_count_clear),
        .o_equalizer_gain_code(o_equalizer_gain_code));

    link_host_model u_host (.i_link_clk(i_link_clk), .i_ack(o_rem_ack),
        .i_busy(o_rem_busy), .i_rdata(o_rem_rdata), .o_req(i_rem_req),
        .o_acc(i_rem_acc));

    ////////////////////////////////////////////////////////////////////
    // comparisons and bus helpers
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // let the next device edge land, then look
    task automatic settle();
        @(posedge i_clk);
        #1;
    endtask

    // local access: the ack stands only until the edge after the taking one
    task automatic loc(input logic wr, input logic [7:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
        @(negedge i_clk);
        i_loc_req = 1'b1;
        i_loc_acc = {wr, a, wd};
        @(negedge i_clk);
        cmp_bit(o_loc_ack, 1'b1);
        rd = o_loc_rdata;
        i_loc_req = 1'b0;
        i_loc_acc = ~i_loc_acc;
    endtask

    // configuration write, then wait for the decoded levels
    task automatic cfg_wr(input logic [7:0] v);
        logic [7:0] d;
        loc(1'b1, 8'h03, v, d);
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset();
        logic [7:0] d;
        loc(1'b0, 8'h03, 8'h00, d);
        cmp_byte(d, 8'hE9);
        cmp_byte({1'b0, o_config}, 8'h75);
        loc(1'b0, 8'h04, 8'h00, d);
        cmp_byte(d, 8'h00);
        loc(1'b0, 8'h10, 8'h00, d);
        cmp_byte(d, 8'h00);
        $display("test_reset done");
    endtask

    // walking one over every level bit, bit 1 left out
    task automatic test_bits();
        logic [7:0] p, d;
        for (int i = 0; i < 8; i++)
        begin
            p = (i == 1) ? 8'h00 : 8'h01 << i;
            cfg_wr(p);
            cmp_bit(o_config.parity_check_en, p[7]);
            cmp_bit(o_config.crc_gen_en, p[6]);
            cmp_bit(o_config.io_supply_auto, p[5]);
            cmp_bit(o_config.io_supply_3v3_select, p[4]);
            cmp_bit(o_config.passthrough_en, p[3]);
            cmp_bit(o_config.remote_write_autoack, p[2]);
            cmp_bit(o_config.output_sample_edge_select, p[0]);
            loc(1'b0, 8'h03, 8'h00, d);
            cmp_byte(d, p);
        end
        $display("test_bits done");
    endtask

    // clear pulse comes once and the bit reads back as zero
    task automatic test_clear();
        logic [7:0] d;
        loc(1'b1, 8'h03, 8'hEB, d);
        cmp_bit(o_parity_count_clear, 1'b0);
        settle();
        cmp_bit(o_parity_count_clear, 1'b1);
        settle();
        cmp_bit(o_parity_count_clear, 1'b0);
        loc(1'b0, 8'h03, 8'h00, d);
        cmp_byte(d, 8'hE9);
        $display("test_clear done");
    endtask

    // auto mode follows the pin, manual mode follows bit 4
    task automatic test_io();
        cfg_wr(8'h20);
        @(negedge i_clk);
        i_io_supply_detect_3v3 = 1'b1;
        repeat (4) settle();
        cmp_bit(o_io_supply_level_3v3, 1'b1);
        cfg_wr(8'h00);
        cmp_bit(o_io_supply_level_3v3, 1'b0);
        @(negedge i_clk);
        i_io_supply_detect_3v3 = 1'b0;
        cfg_wr(8'h10);
        cmp_bit(o_io_supply_level_3v3, 1'b1);
        $display("test_io done");
    endtask

    task automatic test_eq();
        logic [7:0] d;
        loc(1'b1, 8'h04, 8'h3F, d);
        i_adaptive_equalizer_gain = 8'h5A;
        i_adaptive_equalizer_bypass = 1'b1;
        repeat (2) settle();
        cmp_byte(o_equalizer_gain_code, 8'h3F);
        @(negedge i_clk);
        i_adaptive_equalizer_bypass = 1'b0;
        repeat (2) settle();
        cmp_byte(o_equalizer_gain_code, 8'h5A);
        $display("test_eq done");
    endtask

    // one forwarded transaction and its outcome
    task automatic fwd(input fwd_request_type f, input logic [6:0] ea,
                       input logic ack);
        @(negedge i_clk);
        i_fwd_req = 1'b1;
        i_fwd = f;
        // valid and early ack stand for this one cycle only
        @(negedge i_clk);
        cmp_bit(o_fwd_valid, 1'b1);
        cmp_bit(o_fwd_write, f.write);
        cmp_byte({1'b0, o_fwd_addr}, {1'b0, ea});
        cmp_bit(o_fwd_early_ack, ack);
        i_fwd_req = 1'b0;
        i_fwd = ~f;
        settle();
        cmp_bit(o_fwd_valid, 1'b0);
    endtask

    task automatic test_fwd();
        // the bench treats the link as up, so auto-ack may be set
        cfg_wr(8'h04);
        fwd({1'b1, 1'b1, 1'b0, 7'h11}, 7'h2B, 1'b1);
        fwd({1'b0, 1'b1, 1'b0, 7'h11}, 7'h2B, 1'b0);
        fwd({1'b1, 1'b0, 1'b1, 7'h33}, 7'h33, 1'b1);
        fwd({1'b1, 1'b0, 1'b0, 7'h33}, 7'h33, 1'b0);
        cfg_wr(8'h00);
        fwd({1'b1, 1'b1, 1'b0, 7'h11}, 7'h2B, 1'b0);
        $display("test_fwd done");
    endtask

    // remote write seen locally, remote read of a local write
    task automatic test_remote();
        logic [7:0] d;
        logic b;
        bit ok;
        u_host.access({1'b1, 8'h04, 8'hA5}, d, b, ok);
        cmp_bit(ok, 1'b1);
        if (!ok)
            close_out();
        cmp_bit(b, 1'b1);
        cmp_bit(o_rem_busy, 1'b0);
        loc(1'b0, 8'h04, 8'h00, d);
        cmp_byte(d, 8'hA5);
        cfg_wr(8'h99);
        u_host.access({1'b0, 8'h03, 8'h00}, d, b, ok);
        cmp_bit(ok, 1'b1);
        if (!ok)
            close_out();
        cmp_bit(b, 1'b1);
        cmp_byte(d, 8'h99);
        $display("test_remote done");
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (16) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        test_reset();
        test_bits();
        test_clear();
        test_io();
        test_eq();
        test_fwd();
        test_remote();
        close_out();
    end
endmodule

// >>> tb/link_host_model.sv
`timescale 1ns/1ps
// far-side requester on the control channel clock
module link_host_model
    import deser_link_config_pkg::*;
(
    // control channel clock and answer
    input wire logic i_link_clk,
    input wire logic i_ack,
    input wire logic i_busy,
    input wire logic [7:0] i_rdata,
    // request toward the bank
    output logic o_req,
    output reg_access_type o_acc
);
    initial
    begin
        o_req = 1'b0;
        o_acc = '0;
    end

    // one access: pulse while idle, then a bounded wait for the answer
    task automatic access(input reg_access_type a, output logic [7:0] d,
                          output logic b, output bit ok);
        int n;
        @(negedge i_link_clk);
        o_req = 1'b1;
        o_acc = a;
        @(negedge i_link_clk);
        // taken at the edge just passed, so busy already shows
        b = i_busy;
        o_req = 1'b0;
        // released fields change, so a stale copy is never trusted
        o_acc = ~a;
        ok = 1'b0;
        n = 0;
        while (!ok && n < 60)
        begin
            // look between edges, where ack and read data have settled
            @(negedge i_link_clk);
            ok = (i_ack === 1'b1);
            d = i_rdata;
            n++;
        end
    endtask
endmodule
